// ==== rtl/iprp_pkg.sv ====
/*
 Package for the interrupt priority register pair: offsets, field layout, reset values and bus types.
 Assumes a 16-bit register set reached over a 32-bit Avalon-MM slave, one aligned word per register.
*/
package iprp_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_PRIO_A = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_PRIO_B = 4'h4;
	localparam int FIELD_W = 3;
	localparam int FIELDS = 4;
	localparam int REG_W = 16;
	localparam logic [FIELD_W-1:0] PRIO_RESET = 3'h4;
	localparam logic [FIELD_W-1:0] PRIO_OFF = 3'h0;
	localparam int POS_F0 = 12;
	localparam int POS_F1 = 8;
	localparam int POS_F2 = 4;
	localparam int POS_F3 = 0;
	localparam logic [REG_W-1:0] MASK_A = 16'h7770;
	localparam logic [REG_W-1:0] MASK_B = 16'h7777;
	localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

	typedef struct packed {
		logic [FIELD_W-1:0] timerBPrio;
		logic [FIELD_W-1:0] compareBPrio;
		logic [FIELD_W-1:0] captureBPrio;
		logic [FIELD_W-1:0] serialAReceivePrio;
		logic [FIELD_W-1:0] syncSerialAEventPrio;
		logic [FIELD_W-1:0] syncSerialAFaultPrio;
		logic [FIELD_W-1:0] timerCPrio;
	} iprp_prio_type;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} iprp_req_type;
endpackage : iprp_pkg

// ==== rtl/iprp_field.sv ====
/*
 One 3-bit priority field: storage, write update and disable decode.
 Assumes write strobes come from the bus slave in the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module iprp_field
	import iprp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wrEn,
	input wire logic [FIELD_W-1:0] wrData,
	output logic [FIELD_W-1:0] prio,
	output logic active
);
	logic [FIELD_W-1:0] prio_q, prio_d;
	logic active_q, active_d;

	always_comb begin
		prio_d = prio_q;
		if (wrEn) begin
			prio_d = wrData;
		end
		active_d = (prio_d != PRIO_OFF);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prio_q <= PRIO_RESET;
			active_q <= 1'b1;
		end else begin
			prio_q <= prio_d;
			active_q <= active_d;
		end
	end

	assign prio = prio_q;
	assign active = active_q;

	chk_disable_tracks: assert property (@(posedge ref_clk) disable iff (!nrst)
		active_q == (prio_q != PRIO_OFF)) else $error("active flag disagrees with field");
endmodule : iprp_field
`default_nettype wire

// ==== rtl/iprp_regs.sv ====
/*
 Interrupt priority register pair with a 32-bit Avalon-MM slave.
 Assumes the arbiter uses the presented levels 1 to 7, 7 highest, and ignores disabled sources.
*/
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
// Summary of operation
// - First register bits 14-12 hold timer B priority, read and write.
// - First register bits 10-8 hold compare B priority, read and write.
// - First register bits 6-4 hold capture B priority, read and write.
// - Second register bits 10-8 sync serial event, bits 6-4 sync serial fault.
// - Second register bits 2-0 hold timer C priority.
// - Code 111 means level 7, the highest priority.
// - Code 001 means level 1; codes between map linearly.
// - Code 000 disables the source; it never requests.
// - Unimplemented bits ignore writes and read as zero.
// - Every field resets to 100, priority 4.
`timescale 1ns/100ps
`default_nettype none
module iprp_regs
	import iprp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output iprp_prio_type prioOut,
	output logic [6:0] srcActive
);
	localparam int NSRC = 7;
	localparam int POS [NSRC] = '{POS_F0, POS_F1, POS_F2, POS_F0, POS_F1, POS_F2, POS_F3};
	localparam bit IN_B [NSRC] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

	initial begin
		if (ADDR_W < 3) begin
			$error("address too narrow for the register map");
		end
	end

	typedef enum logic [0:0] {
		IPRP_IDLE_ST = 1'b0,
		IPRP_DONE_ST = 1'b1
	} iprp_state_type;

	iprp_state_type state_q, state_d;
	logic [31:0] rdata_q, rdata_d;
	logic wait_q, wait_d;
	logic selA, selB, acc, wrA, wrB;
	logic rdA, rdB;
	logic fresh_q, fresh_d;
	logic [NSRC-1:0] wrEn;
	logic [FIELD_W-1:0] prio [NSRC];
	logic [NSRC-1:0] act;
	logic [REG_W-1:0] regA, regB;

	assign selA = (avs_address == OFS_PRIO_A);
	assign selB = (avs_address == OFS_PRIO_B);
	assign acc = avs_read | avs_write;
	assign wrA = avs_write && selA && (state_q == IPRP_IDLE_ST);
	assign wrB = avs_write && selB && (state_q == IPRP_IDLE_ST);
	assign rdA = avs_read && selA && (state_q == IPRP_IDLE_ST);
	assign rdB = avs_read && selB && (state_q == IPRP_IDLE_ST);

	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_field
			// Fields of 14-12 and 10-8 live in byte lane 1, the rest in lane 0.
			localparam int LANE = (POS[gi] >= 8) ? 1 : 0;
			assign wrEn[gi] = (IN_B[gi] ? wrB : wrA) && avs_byteenable[LANE];
			iprp_field u_field (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.wrEn(wrEn[gi]),
				.wrData(avs_writedata[POS[gi] +: FIELD_W]),
				.prio(prio[gi]),
				.active(act[gi])
			);
		end
	endgenerate

	always_comb begin
		regA = '0;
		regB = '0;
		regA[POS_F0 +: FIELD_W] = prio[0];
		regA[POS_F1 +: FIELD_W] = prio[1];
		regA[POS_F2 +: FIELD_W] = prio[2];
		regB[POS_F0 +: FIELD_W] = prio[3];
		regB[POS_F1 +: FIELD_W] = prio[4];
		regB[POS_F2 +: FIELD_W] = prio[5];
		regB[POS_F3 +: FIELD_W] = prio[6];
	end

	// Each access takes two cycles: the request is accepted, then answered with waitrequest low.
	always_comb begin
		state_d = state_q;
		rdata_d = rdata_q;
		wait_d = 1'b1;
		case (state_q)
			IPRP_IDLE_ST: begin
				if (acc) begin
					state_d = IPRP_DONE_ST;
					wait_d = 1'b0;
					if (selA) begin
						rdata_d = {16'h0000, regA & MASK_A};
					end else if (selB) begin
						rdata_d = {16'h0000, regB & MASK_B};
					end else begin
						rdata_d = READ_UNMAPPED;
					end
				end
			end
			IPRP_DONE_ST: begin
				state_d = IPRP_IDLE_ST;
			end
			default: begin
				state_d = IPRP_IDLE_ST;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= IPRP_IDLE_ST;
			rdata_q <= 32'h00000000;
			wait_q <= 1'b1;
		end else begin
			state_q <= state_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	// Field outputs come straight from each field's flip-flops.
	assign prioOut = '{prio[0], prio[1], prio[2], prio[3], prio[4], prio[5], prio[6]};
	assign srcActive = act;

	chk_write_next_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
		wrA && avs_byteenable[1] |=> prioOut.timerBPrio == $past(avs_writedata[14:12])) else
		$error("timer B field did not take the write");
	chk_compare_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		wrA && avs_byteenable[1] |=> prioOut.compareBPrio == $past(avs_writedata[10:8])) else
		$error("compare B field did not take the write");
	chk_capture_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		wrA && avs_byteenable[0] |=> prioOut.captureBPrio == $past(avs_writedata[6:4])) else
		$error("capture B field did not take the write");
	chk_receive_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		wrB && avs_byteenable[1] |=> prioOut.serialAReceivePrio == $past(avs_writedata[14:12])) else
		$error("receive field did not take the write");
	chk_fault_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		wrB && avs_byteenable[0] |=> prioOut.syncSerialAFaultPrio == $past(avs_writedata[6:4])) else
		$error("fault field did not take the write");
	chk_timerc_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		wrB && avs_byteenable[0] |=> prioOut.timerCPrio == $past(avs_writedata[2:0])) else
		$error("timer C field did not take the write");
	chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		!avs_waitrequest |-> avs_readdata[31:15] == 17'h0 && avs_readdata[11] == 1'b0
		&& avs_readdata[7] == 1'b0) else $error("reserved bits read nonzero");
	chk_answer_once: assert property (@(posedge ref_clk) disable iff (!nrst)
		acc && state_q == IPRP_IDLE_ST |=> !avs_waitrequest ##1 avs_waitrequest) else
		$error("bus answer timing wrong");
	chk_unheld_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		!wrB |=> $stable(prioOut.syncSerialAEventPrio)) else $error("event field changed without write");
	chk_active_level: assert property (@(posedge ref_clk) disable iff (!nrst)
		srcActive[6] == (prioOut.timerCPrio != PRIO_OFF)) else $error("disable decode wrong");

	// Marks the first cycle after reset so that the default levels can be checked once.
	always_comb begin
		fresh_d = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= fresh_d;
		end
	end

	// Every field leaves reset at the default level.
	chk_reset_default: assert property (@(posedge ref_clk) disable iff (!nrst)
		fresh_q
		|-> prioOut == {7{PRIO_RESET}})
		else $error("field not at default level after reset");

	chk_reset_active: assert property (@(posedge ref_clk) disable iff (!nrst)
		fresh_q
		|-> srcActive == 7'h7f)
		else $error("source not active after reset");

	// The event field takes a write in its byte lane.
	chk_event_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		wrB && avs_byteenable[1]
		|=> prioOut.syncSerialAEventPrio == $past(avs_writedata[10:8]))
		else $error("event field did not take the write");

	// A field keeps its level unless its own register and lane are written.
	chk_timerb_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(wrA && avs_byteenable[1])
		|=> $stable(prioOut.timerBPrio))
		else $error("timer B field changed without write");

	chk_compare_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(wrA && avs_byteenable[1])
		|=> $stable(prioOut.compareBPrio))
		else $error("compare B field changed without write");

	chk_capture_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(wrA && avs_byteenable[0])
		|=> $stable(prioOut.captureBPrio))
		else $error("capture B field changed without write");

	chk_receive_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(wrB && avs_byteenable[1])
		|=> $stable(prioOut.serialAReceivePrio))
		else $error("receive field changed without write");

	chk_event_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(wrB && avs_byteenable[1])
		|=> $stable(prioOut.syncSerialAEventPrio))
		else $error("event field changed without write");

	chk_fault_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(wrB && avs_byteenable[0])
		|=> $stable(prioOut.syncSerialAFaultPrio))
		else $error("fault field changed without write");

	chk_timerc_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(wrB && avs_byteenable[0])
		|=> $stable(prioOut.timerCPrio))
		else $error("timer C field changed without write");

	// A read answers with the levels that stood when it was taken.
	chk_timerb_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdA
		|=> avs_readdata[14:12] == $past(prioOut.timerBPrio))
		else $error("timer B field read back wrong");

	chk_compare_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdA
		|=> avs_readdata[10:8] == $past(prioOut.compareBPrio))
		else $error("compare B field read back wrong");

	chk_capture_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdA
		|=> avs_readdata[6:4] == $past(prioOut.captureBPrio))
		else $error("capture B field read back wrong");

	chk_receive_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdB
		|=> avs_readdata[14:12] == $past(prioOut.serialAReceivePrio))
		else $error("receive field read back wrong");

	chk_event_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdB
		|=> avs_readdata[10:8] == $past(prioOut.syncSerialAEventPrio))
		else $error("event field read back wrong");

	chk_fault_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdB
		|=> avs_readdata[6:4] == $past(prioOut.syncSerialAFaultPrio))
		else $error("fault field read back wrong");

	chk_timerc_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdB
		|=> avs_readdata[2:0] == $past(prioOut.timerCPrio))
		else $error("timer C field read back wrong");

	// Unimplemented bits of each register read as zero.
	chk_low_nibble_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdA
		|=> avs_readdata[3:0] == 4'h0)
		else $error("low bits of first register read nonzero");

	chk_bit3_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		rdB
		|=> avs_readdata[3] == 1'b0)
		else $error("bit 3 of second register read nonzero");

	chk_unmapped_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		avs_read && !selA && !selB && state_q == IPRP_IDLE_ST
		|=> avs_readdata == READ_UNMAPPED)
		else $error("unmapped read not zero");

	// Each source is disabled exactly when its code is zero.
	chk_active_timerb: assert property (@(posedge ref_clk) disable iff (!nrst)
		srcActive[0] == (prioOut.timerBPrio != PRIO_OFF))
		else $error("timer B disable decode wrong");

	chk_active_compare: assert property (@(posedge ref_clk) disable iff (!nrst)
		srcActive[1] == (prioOut.compareBPrio != PRIO_OFF))
		else $error("compare B disable decode wrong");

	chk_active_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
		srcActive[2] == (prioOut.captureBPrio != PRIO_OFF))
		else $error("capture B disable decode wrong");

	chk_active_receive: assert property (@(posedge ref_clk) disable iff (!nrst)
		srcActive[3] == (prioOut.serialAReceivePrio != PRIO_OFF))
		else $error("receive disable decode wrong");

	chk_active_event: assert property (@(posedge ref_clk) disable iff (!nrst)
		srcActive[4] == (prioOut.syncSerialAEventPrio != PRIO_OFF))
		else $error("event disable decode wrong");

	chk_active_fault: assert property (@(posedge ref_clk) disable iff (!nrst)
		srcActive[5] == (prioOut.syncSerialAFaultPrio != PRIO_OFF))
		else $error("fault disable decode wrong");

	// Waitrequest is low only in the answer cycle.
	chk_wait_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
		!avs_waitrequest
		|-> state_q == IPRP_DONE_ST)
		else $error("waitrequest low outside the answer cycle");

	chk_answer_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
		state_q == IPRP_DONE_ST
		|-> !avs_waitrequest)
		else $error("answer cycle without waitrequest low");

	cov_write_a: cover property (@(posedge ref_clk) disable iff (!nrst) wrA);
	cov_write_b: cover property (@(posedge ref_clk) disable iff (!nrst) wrB);
	cov_read_any: cover property (@(posedge ref_clk) disable iff (!nrst) avs_read ##1 !avs_waitrequest);
	cov_disable: cover property (@(posedge ref_clk) disable iff (!nrst) srcActive != 7'h7f);
	cov_top_level: cover property (@(posedge ref_clk) disable iff (!nrst) prioOut.timerCPrio == 3'h7);
endmodule : iprp_regs
`default_nettype wire

// ==== test/test_interrupt_priority_regs_pair.sv ====
/*
 Self-checking bench for the interrupt priority register pair, with a behavioural register model.
 Assumes the package and the register module are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_priority_regs_pair
	import iprp_pkg::*;
;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [ADDR_W-1:0] avsAddress = '0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = '0;
	logic [3:0] avsByteenable = '0;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	iprp_prio_type prioOut;
	logic [6:0] srcActive;
	int failCount = 0;
	int testsRun = 0;
	int seed = 32'hf3e4;
	int modelA;
	int modelB;

	iprp_regs DUT (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avsAddress), .avs_read(avsRead),
		.avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .prioOut(prioOut), .srcActive(srcActive));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
		testsRun++;
		if (seen !== expected) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", what, expected, seen);
		end
	endtask : check

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : printVerdict

	task automatic checkOutputs();
		logic [20:0] expPrio;
		logic [6:0] expActive;
		expPrio = {modelA[14:12], modelA[10:8], modelA[6:4], modelB[14:12], modelB[10:8], modelB[6:4], modelB[2:0]};
		for (int k = 0; k < 7; k++) begin
			expActive[k] = (expPrio[20-3*k -: 3] != 3'h0);
		end
		check("prioOut", 32'(prioOut), 32'(expPrio));
		check("srcActive", 32'(srcActive), 32'(expActive));
	endtask : checkOutputs

	// One Avalon cycle, sampled at rising edges; the model takes the write before the outputs are compared.
	task automatic access(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd, input logic [3:0] be);
		int n;
		int lanes;
		n = 0;
		lanes = {16'h0, {8{be[1]}}, {8{be[0]}}};
		@(posedge ref_clk);
		avsAddress <= addr;
		avsRead <= ~wr;
		avsWrite <= wr;
		avsWritedata <= wd;
		avsByteenable <= be;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 50);
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		if (n >= 50) begin
			check("waitrequest", 32'(avsWaitrequest), 32'h0);
		end
		if (wr && addr == OFS_PRIO_A) begin
			modelA = (modelA & ~(MASK_A & lanes)) | (wd & MASK_A & lanes);
		end
		if (wr && addr == OFS_PRIO_B) begin
			modelB = (modelB & ~(MASK_B & lanes)) | (wd & MASK_B & lanes);
		end
		if (!wr) begin
			check("readdata", avsReaddata, (addr == OFS_PRIO_A) ? modelA : (addr == OFS_PRIO_B) ? modelB : READ_UNMAPPED);
		end
		checkOutputs();
	endtask : access

	initial begin
		for (int pass = 0; pass < 2; pass++) begin
			@(posedge ref_clk);
			nrst <= 1'b0;
			repeat (10) @(posedge ref_clk);
			nrst <= 1'b1;
			modelA = 16'h4440;
			modelB = 16'h4444;
			@(negedge ref_clk);
			checkOutputs();
			access(1'b0, OFS_PRIO_A, 32'h0, 4'hf);
			access(1'b0, OFS_PRIO_B, 32'h0, 4'hf);
			for (int code = 7; code >= 0; code--) begin
				access(1'b1, OFS_PRIO_A, {16'hffff, 1'b1, 3'(code), 1'b1, 3'(code), 1'b1, 3'(code), 1'b1, 3'(code)}, 4'hf);
				access(1'b1, OFS_PRIO_B, {16'hffff, 1'b1, 3'(code), 1'b1, 3'(code), 1'b1, 3'(code), 1'b1, 3'(code)}, 4'hf);
				access(1'b0, OFS_PRIO_A, 32'h0, 4'hf);
				access(1'b0, OFS_PRIO_B, 32'h0, 4'hf);
			end
			for (int i = 0; i < 60; i++) begin
				access(1'($random(seed)), 4'(($random(seed) & 3) * 4), $random(seed), 4'($random(seed)));
			end
		end
		printVerdict();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		failCount++;
		printVerdict();
	end
endmodule : test_interrupt_priority_regs_pair
`default_nettype wire
